// ### verilog/module_flag_interrupt_timing.sv
`timescale 1ns/1ns
`default_nettype none
module module_flag_interrupt_timing
  import flag_pkg::*;
#(
  parameter int NFLAG     = 6,
  parameter int INIT_CYC  = INIT_MAX_CYC
) (
  // System clock and reset
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // Link-side clock
  input  wire logic              link_clk_i,
  // Host pins
  input  wire logic              module_reset_n_i,
  output logic                   interrupt_request_n_o,
  // Line conditions and fast loss-of-signal mode select
  input  wire logic              rx_los_cond_i,
  input  wire logic              tx_fault_cond_i,
  input  wire logic [NFLAG-3:0]  other_cond_i,
  input  wire logic              fast_los_mode_i,
  // Management side, link clock
  input  wire logic [NFLAG-1:0]  flag_clear_i,
  input  wire logic [NFLAG-1:0]  flag_mask_i,
  input  wire logic              tx_disable_req_i,
  input  wire app_mode_t         app_mode_i,
  output logic [NFLAG-1:0]       flags_o,
  // Status, system clock
  output status_t                status_o,
  output media_id_t              media_id_o
);

  logic             rst_s1_r;
  logic             rst_n_r;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  logic             lrst_s1_r;
  logic             lrst_n_r;
  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lrst_s1_r <= 1'b0;
      lrst_n_r  <= 1'b0;
    end else begin
      lrst_s1_r <= 1'b1;
      lrst_n_r  <= lrst_s1_r;
    end
  end

  // Core flags, mirrored bit by bit into the link domain below
  logic [NFLAG-1:0] flag_r;

  // Link domain: clear requests become toggles
  logic [NFLAG-1:0] clr_tgl_r;
  logic [NFLAG-1:0] flg_s1_r;
  logic [NFLAG-1:0] flags_r;
  always_ff @(posedge link_clk_i or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      clr_tgl_r <= '0;
      flg_s1_r  <= '0;
      flags_r   <= '0;
    end else begin
      clr_tgl_r <= clr_tgl_r ^ flag_clear_i;
      flg_s1_r  <= flag_r;
      flags_r   <= flg_s1_r;
    end
  end
  assign flags_o = flags_r;

  // Pin and cross-domain synchronisers
  // Low end first: reset pin, fast mode, mode word, tx disable, conditions, masks, toggles
  localparam int SW = NFLAG * 3 + 6;
  logic [SW-1:0]    sync_in;
  logic [SW-1:0]    s1_r;
  logic [SW-1:0]    s2_r;
  assign sync_in = {clr_tgl_r, flag_mask_i, other_cond_i, tx_fault_cond_i,
                    rx_los_cond_i, tx_disable_req_i, app_mode_i,
                    fast_los_mode_i, module_reset_n_i};
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= sync_in;
      s2_r <= s1_r;
    end
  end

  logic [NFLAG-1:0] clr_tgl_s;
  logic [NFLAG-1:0] mask_s;
  logic [NFLAG-1:0] cond_s;
  logic             txdis_s;
  app_mode_t        mode_s;
  logic             zr_s;
  logic             fast_s;
  logic             mrst_s;
  assign clr_tgl_s = s2_r[SW-1 -: NFLAG];
  assign mask_s    = s2_r[SW-1-NFLAG -: NFLAG];
  assign cond_s    = s2_r[NFLAG+5 : 6];
  assign txdis_s   = s2_r[5];
  assign mode_s    = app_mode_t'(s2_r[4:2]);
  assign zr_s      = (mode_s == APP_ZR400);
  assign fast_s    = s2_r[1];
  assign mrst_s    = s2_r[0];

  // Module reset pulse measurement
  logic [31:0]      low_cnt_r;
  logic             mrst_d_r;
  logic             mrst_req;
  logic             low_long;
  assign low_long = low_cnt_r >= 32'(RST_MIN_CYC);
  assign mrst_req = mrst_s && !mrst_d_r && low_long;
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      low_cnt_r <= '0;
      mrst_d_r  <= 1'b1;
    end else begin
      mrst_d_r  <= mrst_s;
      if (mrst_s) begin
        low_cnt_r <= '0;
      end else if (!low_long) begin
        low_cnt_r <= low_cnt_r + 32'h1;
      end
    end
  end

  // Management initialisation
  mgmt_state_t      st_r;
  mgmt_state_t      st_nxt;
  logic [31:0]      init_cnt_r;
  logic             init_done;
  logic             busy;
  assign init_done = init_cnt_r >= 32'(INIT_CYC - 1);
  // The accepted rising edge counts as busy, before st_r is back in init
  assign busy      = (st_r == ST_INIT) || !mrst_s || mrst_req;
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_INIT: begin
        if (init_done && mrst_s) begin
          st_nxt = ST_READY;
        end
      end
      default: begin
        if (mrst_req) begin
          st_nxt = ST_INIT;
        end
      end
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r       <= ST_INIT;
      init_cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      if (st_r == ST_READY || !mrst_s) begin
        init_cnt_r <= '0;
      end else if (!init_done) begin
        init_cnt_r <= init_cnt_r + 32'h1;
      end
    end
  end

  // Latched flags; a set wins over a clear in the same cycle
  logic [NFLAG-1:0] cond_d_r;
  logic [NFLAG-1:0] clr_d_r;
  logic [NFLAG-1:0] flag_set;
  logic [NFLAG-1:0] flag_clr;
  logic [NFLAG-1:0] flag_nxt;
  logic [NFLAG-1:0] unmasked;
  assign flag_set = cond_s & ~cond_d_r & {NFLAG{!busy}};
  assign flag_clr = clr_tgl_s ^ clr_d_r;
  assign flag_nxt = busy ? '0 : (flag_set | (flag_r & ~flag_clr));
  assign unmasked = flag_r & ~mask_s;
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cond_d_r <= '0;
      clr_d_r  <= '0;
      flag_r   <= '0;
    end else begin
      cond_d_r <= cond_s;
      clr_d_r  <= clr_tgl_s;
      flag_r   <= flag_nxt;
    end
  end

  // Interrupt line and status
  logic             int_n_r;
  status_t          status_r;
  media_id_t        mid_r;
  media_id_t        mid_nxt;
  app_mode_t        mode_d_r;
  logic             mode_stable;
  // Mode word crosses as a bus: take it only once two samples agree
  assign mode_stable = (mode_s == mode_d_r);
  always_comb begin
    mid_nxt = '{secondary: MID_NONE, primary: MID_NONE};
    if (zr_s) begin
      mid_nxt = '{secondary: MID_ZR400_B, primary: MID_ZR400_A};
    end else if (mode_s == APP_ZRP400) begin
      mid_nxt.primary = MID_ZRP400;
    end else if (mode_s == APP_ZRP300) begin
      mid_nxt.primary = MID_ZRP300;
    end else if (mode_s == APP_ZRP200) begin
      mid_nxt.primary = MID_ZRP200;
    end else if (mode_s == APP_ZRP100) begin
      mid_nxt.primary = MID_ZRP100;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      int_n_r  <= 1'b1;
      status_r <= '{management_init_state: 1'b1, tx_enable: 1'b0, rx_los: 1'b0};
      mid_r    <= '0;
      mode_d_r <= APP_ZR400;
    end else begin
      int_n_r  <= ~|unmasked;
      status_r.management_init_state <= busy;
      status_r.tx_enable <= !txdis_s && !busy;
      status_r.rx_los    <= cond_s[FLAG_RX_LOS] && !busy;
      mode_d_r <= mode_s;
      if (mode_stable) begin
        mid_r  <= mid_nxt;
      end
    end
  end
  assign interrupt_request_n_o = int_n_r;
  assign status_o              = status_r;
  assign media_id_o            = mid_r;

  // Fast mode shares the immediate path; fast_los_a holds it to the same two-cycle bound as int_assert_a

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_r);

  init_bound_a: assert property (
    st_r == ST_INIT && mrst_s |-> init_cnt_r < 32'(INIT_CYC))
    else $error("init counter passed its bound");
  reset_pulse_a: assert property (
    mrst_req |-> low_cnt_r >= 32'(RST_MIN_CYC) && st_nxt == ST_INIT)
    else $error("short reset pulse accepted");
  restart_a: assert property (
    mrst_req |=> st_r == ST_INIT && init_cnt_r <= 32'h1)
    else $error("accepted reset did not restart init");
  busy_clear_a: assert property (
    busy |=> flag_r == '0 && !status_o.tx_enable && status_o.management_init_state)
    else $error("flags or transmitter active during init");
  int_assert_a: assert property (
    (|(flag_set & ~mask_s)) |=> ##1 !interrupt_request_n_o)
    else $error("interrupt not asserted after flag set");
  int_release_a: assert property (
    !busy && (flag_r & ~mask_s) == (flag_clr & flag_r & ~mask_s) && |flag_clr
    && !(|flag_set) && $stable(mask_s) |=> ##1 interrupt_request_n_o)
    else $error("interrupt not released after clear");
  clear_a: assert property (
    |(flag_clr & ~flag_set) |=> !(|(flag_r & $past(flag_clr & ~flag_set))))
    else $error("read flag not cleared");
  set_wins_a: assert property (
    |flag_set |=> (flag_r & $past(flag_set)) == $past(flag_set))
    else $error("flag set lost");
  int_hold_a: assert property (
    |(flag_r & ~mask_s) |=> !interrupt_request_n_o)
    else $error("interrupt released with unmasked flag set");
  int_idle_a: assert property (
    !(|(flag_r & ~mask_s)) |=> interrupt_request_n_o)
    else $error("interrupt held with no unmasked flag");
  los_set_a: assert property (
    cond_s[FLAG_RX_LOS] && !cond_d_r[FLAG_RX_LOS] && !busy |=> flag_r[FLAG_RX_LOS])
    else $error("loss-of-signal flag not set");
  fast_los_a: assert property (
    fast_s && cond_s[FLAG_RX_LOS] && !cond_d_r[FLAG_RX_LOS] && !busy
    |=> ##1 (!interrupt_request_n_o || $past(mask_s[FLAG_RX_LOS])))
    else $error("fast loss-of-signal interrupt late");
  los_clear_a: assert property (
    $fell(cond_s[FLAG_RX_LOS]) |=> !status_o.rx_los)
    else $error("loss-of-signal indication held");
  txf_set_a: assert property (
    $rose(cond_s[FLAG_TX_FAULT]) && !busy |=> flag_r[FLAG_TX_FAULT] ##1
    (!interrupt_request_n_o || mask_s[FLAG_TX_FAULT] || !$stable(mask_s)))
    else $error("transmit fault not flagged");
  mask_on_a: assert property (
    (&mask_s) [*2] |=> interrupt_request_n_o)
    else $error("masked flags still interrupt");
  mask_off_a: assert property (
    |(flag_r & $past(mask_s) & ~mask_s) |=> !interrupt_request_n_o)
    else $error("unmask did not resume interrupt");
  txdis_a: assert property (
    txdis_s |=> !status_o.tx_enable)
    else $error("transmitter not disabled");
  txen_a: assert property (
    !txdis_s && !busy |=> status_o.tx_enable)
    else $error("transmitter not re-enabled");
  media_a: assert property (
    zr_s && mode_d_r == APP_ZR400 |=> media_id_o == {MID_ZR400_B, MID_ZR400_A})
    else $error("media identifier wrong");

endmodule
`default_nettype wire

// ### verilog/flag_pkg.sv
package flag_pkg;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int INIT_MAX_MS    = 2000;
  localparam int RST_MIN_US     = 10;
  localparam int INIT_MAX_CYC   = INIT_MAX_MS * (1000000 / CLK_PERIOD_NS);
  localparam int RST_MIN_CYC    = (RST_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLAG_RX_LOS    = 0;
  localparam int FLAG_TX_FAULT  = 1;
  localparam int FLAG_OTHER_LO  = 2;
  localparam logic [7:0] MID_ZR400_A = 8'h3E;
  localparam logic [7:0] MID_ZR400_B = 8'h3F;
  localparam logic [7:0] MID_ZRP400  = 8'h46;
  localparam logic [7:0] MID_ZRP300  = 8'h47;
  localparam logic [7:0] MID_ZRP200  = 8'h48;
  localparam logic [7:0] MID_ZRP100  = 8'h49;
  localparam logic [7:0] MID_NONE    = 8'h00;

  typedef enum logic [2:0] {
    APP_ZR400  = 3'h0,
    APP_ZRP400 = 3'h1,
    APP_ZRP300 = 3'h2,
    APP_ZRP200 = 3'h3,
    APP_ZRP100 = 3'h4
  } app_mode_t;

  typedef enum logic [0:0] {
    ST_INIT  = 1'h0,
    ST_READY = 1'h1
  } mgmt_state_t;

  typedef struct packed {
    logic       management_init_state;
    logic       tx_enable;
    logic       rx_los;
  } status_t;

  typedef struct packed {
    logic [7:0] secondary;
    logic [7:0] primary;
  } media_id_t;
endpackage

// ### sim/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model #(
  parameter int NFLAG = 6
) (
  // Management clock
  input  wire logic         link_clk_i,
  // Management outputs
  output logic [NFLAG-1:0]  flag_clear_o,
  output logic [NFLAG-1:0]  flag_mask_o,
  output logic              tx_disable_req_o
);
  initial begin
    flag_clear_o = '0;
    flag_mask_o = '0;
    tx_disable_req_o = 1'h0;
  end

  // Clear-on-read as a one-cycle pulse, spaced so clears never merge
  task automatic read_clear(input logic [NFLAG-1:0] bits);
    @(negedge link_clk_i);
    flag_clear_o = bits;
    @(negedge link_clk_i);
    flag_clear_o = '0;
    repeat (2) @(negedge link_clk_i);
  endtask

  task automatic set_ctl(input logic [NFLAG-1:0] mask, input logic dis);
    @(negedge link_clk_i);
    flag_mask_o = mask;
    tx_disable_req_o = dis;
  endtask
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import flag_pkg::*;
  localparam int NF = 6;
  localparam int ICYC = 100;
  logic          clk, link_clk, rstn, mrst_n, los, txf, fast, irq_n;
  logic [NF-3:0] oth;
  logic [NF-1:0] clr, msk, flags;
  logic          txdis;
  app_mode_t     mode;
  status_t       st;
  media_id_t     mid;
  int            fail_count = 0;
  int            total_checks = 0;

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial begin
    link_clk = 1'h0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  host_model #(.NFLAG(NF)) host (.link_clk_i(link_clk), .flag_clear_o(clr),
    .flag_mask_o(msk), .tx_disable_req_o(txdis));

  module_flag_interrupt_timing #(.NFLAG(NF), .INIT_CYC(ICYC)) dut (
    .clk_i(clk), .rstn_i(rstn), .link_clk_i(link_clk), .module_reset_n_i(mrst_n),
    .interrupt_request_n_o(irq_n), .rx_los_cond_i(los), .tx_fault_cond_i(txf),
    .other_cond_i(oth), .fast_los_mode_i(fast), .flag_clear_i(clr),
    .flag_mask_i(msk), .tx_disable_req_i(txdis), .app_mode_i(mode),
    .flags_o(flags), .status_o(st), .media_id_o(mid));

  // Probe 0 interrupt, 1 init, 2 tx enable, 3 rx los, 4.. flags
  function automatic logic probe(input int k);
    case (k)
      0: return irq_n;
      1: return st.management_init_state;
      2: return st.tx_enable;
      3: return st.rx_los;
      default: return flags[k-4];
    endcase
  endfunction

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // hold=0: reach v within n cycles; hold=1: v stands for n cycles
  task automatic chk(input int k, input logic v, input int n, input bit hold);
    int i;
    total_checks++;
    for (i = 0; i < n; i++) begin
      @(negedge clk);
      if (hold && probe(k) !== v) begin
        fail_count++;
        $display("MISMATCH t=%0t probe %0d left %b", $time, k, v);
        return;
      end
      if (!hold && probe(k) === v)
        return;
    end
    if (!hold) begin
      fail_count++;
      $display("MISMATCH t=%0t probe %0d never %b", $time, k, v);
      conclude();
    end
  endtask

  task automatic chk_mid(input app_mode_t m, input logic [15:0] exp);
    @(negedge clk);
    mode = m;
    repeat (6) @(negedge clk);
    total_checks++;
    if (mid !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t media id %h", $time, mid);
    end
  endtask

  initial begin
    rstn = 1'h0;
    mrst_n = 1'h1;
    los = 1'h0;
    txf = 1'h0;
    fast = 1'h0;
    oth = '0;
    mode = APP_ZR400;
    repeat (2) @(posedge link_clk);
    @(negedge clk);
    rstn = 1'h1;
    chk(1, 1'h0, ICYC + 10, 0);
    chk(2, 1'h1, 4, 0);
    los = 1'h1;
    chk(0, 1'h0, 8, 0);
    chk(4, 1'h1, 16, 0);
    chk(3, 1'h1, 8, 0);
    txf = 1'h1;
    chk(5, 1'h1, 16, 0);
    los = 1'h0;
    chk(3, 1'h0, 8, 0);
    host.read_clear(6'h01);
    chk(4, 1'h0, 12, 0);
    chk(0, 1'h0, 20, 1);
    host.read_clear(6'h02);
    chk(0, 1'h1, 12, 0);
    fast = 1'h1;
    los = 1'h1;
    chk(0, 1'h0, 8, 0);
    los = 1'h0;
    host.read_clear(6'h01);
    chk(0, 1'h1, 12, 0);
    host.set_ctl(6'h04, 1'h0);
    chk(0, 1'h1, 6, 1);
    oth[0] = 1'h1;
    chk(6, 1'h1, 16, 0);
    chk(0, 1'h1, 20, 1);
    host.set_ctl(6'h00, 1'h0);
    chk(0, 1'h0, 12, 0);
    host.set_ctl(6'h3F, 1'h0);
    chk(0, 1'h1, 12, 0);
    host.set_ctl(6'h00, 1'h1);
    chk(2, 1'h0, 12, 0);
    host.set_ctl(6'h00, 1'h0);
    chk(2, 1'h1, 12, 0);
    host.read_clear(6'h04);
    chk(0, 1'h1, 12, 0);
    chk_mid(APP_ZRP400, {MID_NONE, MID_ZRP400});
    chk_mid(APP_ZRP300, {MID_NONE, MID_ZRP300});
    chk_mid(APP_ZRP200, {MID_NONE, MID_ZRP200});
    chk_mid(APP_ZRP100, {MID_NONE, MID_ZRP100});
    chk_mid(APP_ZR400, {MID_ZR400_B, MID_ZR400_A});
    oth[1] = 1'h1;
    chk(0, 1'h0, 8, 0);
    mrst_n = 1'h0;
    chk(1, 1'h1, 10, 0);
    repeat (RST_MIN_CYC + 10) @(negedge clk);
    mrst_n = 1'h1;
    chk(1, 1'h1, ICYC - 10, 1);
    chk(1, 1'h0, 40, 0);
    chk(7, 1'h0, 20, 0);
    chk(0, 1'h1, 20, 0);
    conclude();
  end
endmodule
`default_nettype wire
